/* File: hw/hsst_sequencer.sv */
// Self-test sequencer of a high-side FET switch controller, with APB registers.
// Assumes synchronous inputs; the ADC answers a held request with valid pulses.
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module hsst_sequencer
  import hsst_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Device supervision
  input  wire logic        watchdog_timeout,
  input  wire logic        hardware_lockout_input,
  input  wire logic        unlock_request,
  // Measurements from normal operation
  input  wire logic [9:0]  short_circuit_meas_field,
  input  wire logic [9:0]  drain_source_meas_field,
  // Converters
  input  wire logic        sense_conv_valid,
  input  wire logic [9:0]  sense_conv_data,
  input  wire logic        ds_conv_valid,
  input  wire logic [9:0]  ds_conv_data,
  output logic             sense_conv_req,
  output logic             ds_conv_req,
  // Analog test stimuli
  output logic             sense_sink_en,
  output logic             ds_offset_en,
  // Switch control
  input  wire logic        fet_cmd,
  input  wire logic        bypass_cmd,
  output logic             fet_drive,
  output logic             bypass_drive,
  // Protection
  input  wire logic        ds_overvoltage_raw,
  output logic             drain_source_overvoltage_fault,
  // State
  output logic             self_test_state,
  output logic             locked_state
);

  typedef struct packed {
    hsst_state_e  state;
    logic [9:0]   cnt;
    hsst_sel_e    sel;
    logic [9:0]   thr;
    logic [9:0]   conv;
    logic [31:0]  rdata;
    logic [10:0]  sense_delta;
    hsst_status_e sense_st;
    logic [10:0]  ds_delta;
    logic         ds_max1;
    hsst_status_e ds_st;
    logic [9:0]   so_val;
    logic         so_fresh;
    logic         so_max2;
    hsst_status_e so_st;
    logic         fet_q;
    logic         byp_q;
  } hsst_regs_s;

  hsst_regs_s r_reg;
  hsst_regs_s r_next;

  logic        acc;
  logic        wr;
  logic        rd_stuck;
  logic        start_cmd;
  logic        stop_cmd;
  logic        lock_evt;
  logic        mapped;
  logic        in_test;
  logic [31:0] rd_mux;

  assign acc       = psel && penable;
  assign wr        = acc && pwrite;
  assign mapped    = (paddr == CTRL_ONE_OFS) || (paddr == CTRL_TWO_OFS) ||
                     (paddr == DS_TEST_OFS) || (paddr == STUCK_TEST_OFS) ||
                     (paddr == SENSE_TEST_OFS) || (paddr == STATE_OFS);
  assign start_cmd = wr && (paddr == CTRL_ONE_OFS) && pwdata[START_BIT];
  assign stop_cmd  = wr && (paddr == CTRL_ONE_OFS) && pwdata[STOP_BIT];
  assign rd_stuck  = acc && !pwrite && (paddr == STUCK_TEST_OFS);
  assign lock_evt  = watchdog_timeout || hardware_lockout_input;
  assign in_test   = (r_reg.state == HSST_ACTIVE) || (r_reg.state == HSST_WAIT) ||
                     (r_reg.state == HSST_STUCK);

  // Zero-wait APB; read data captured in the setup cycle
  assign pready  = acc;
  assign pslverr = acc && !mapped;
  assign prdata  = r_reg.rdata;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      CTRL_ONE_OFS: begin
        rd_mux[SEL_LSB +: 2] = r_reg.sel;
      end
      CTRL_TWO_OFS: begin
        rd_mux[9:0] = r_reg.thr;
      end
      DS_TEST_OFS: begin
        rd_mux[DELTA_LSB +: 11]  = r_reg.ds_delta;
        rd_mux[FLAG_A_BIT]       = r_reg.ds_max1;
        rd_mux[STATUS_LSB +: 2]  = r_reg.ds_st;
      end
      STUCK_TEST_OFS: begin
        rd_mux[DELTA_LSB +: 10]  = r_reg.so_val;
        rd_mux[FLAG_A_BIT]       = r_reg.so_fresh;
        rd_mux[FLAG_B_BIT]       = r_reg.so_max2;
        rd_mux[STATUS_LSB +: 2]  = r_reg.so_st;
      end
      SENSE_TEST_OFS: begin
        rd_mux[DELTA_LSB +: 11]  = r_reg.sense_delta;
        rd_mux[STATUS_LSB +: 2]  = r_reg.sense_st;
      end
      STATE_OFS: begin
        rd_mux[2:0] = r_reg.state;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    r_next = r_reg;
    if (psel && !penable && !pwrite) begin
      r_next.rdata = rd_mux;
    end
    // Selection frozen in a test so the result lands in the right register
    if (wr && (paddr == CTRL_ONE_OFS) && !in_test) begin
      r_next.sel = hsst_sel_e'(pwdata[SEL_LSB +: 2]);
    end
    if (wr && (paddr == CTRL_TWO_OFS)) begin
      r_next.thr = pwdata[9:0];
    end
    // Fresh bit clears on read; a new conversion in that cycle wins
    if (rd_stuck) begin
      r_next.so_fresh = 1'b0;
    end

    unique case (r_reg.state)
      HSST_UNLOCKED: begin
        r_next.fet_q = fet_cmd;
        r_next.byp_q = bypass_cmd;
        if (lock_evt) begin
          r_next.state = HSST_LOCKED;
        end else if (start_cmd) begin
          r_next.cnt = PHASE_CYCLES;
          unique case (hsst_sel_e'(pwdata[SEL_LSB +: 2]))
            HSST_SEL_SENSE: begin
              r_next.state    = HSST_ACTIVE;
              r_next.sense_st = HSST_ST_RUN;
            end
            HSST_SEL_DS: begin
              r_next.state    = HSST_ACTIVE;
              r_next.ds_st    = HSST_ST_RUN;
              r_next.ds_max1  = 1'b0;
            end
            HSST_SEL_STUCK: begin
              r_next.state    = HSST_STUCK;
              r_next.so_st    = HSST_ST_RUN;
              r_next.so_max2  = 1'b0;
              r_next.so_fresh = 1'b0;
            end
            default: begin
              r_next.state = HSST_UNLOCKED;
            end
          endcase
        end
      end
      HSST_ACTIVE: begin
        if (r_reg.sel == HSST_SEL_SENSE && sense_conv_valid) begin
          r_next.conv = sense_conv_data;
        end
        if (r_reg.sel == HSST_SEL_DS && ds_conv_valid) begin
          r_next.conv = ds_conv_data;
        end
        if (r_reg.cnt == 10'h001) begin
          r_next.state = HSST_WAIT;
          r_next.cnt   = PHASE_CYCLES;
        end else begin
          r_next.cnt = r_reg.cnt - 10'h001;
        end
      end
      HSST_WAIT: begin
        if (r_reg.cnt == 10'h001) begin
          r_next.state = HSST_UNLOCKED;
          if (r_reg.sel == HSST_SEL_SENSE) begin
            r_next.sense_delta = {1'b0, r_reg.conv} - {1'b0, short_circuit_meas_field};
            r_next.sense_st    = HSST_ST_END;
          end else begin
            r_next.ds_delta = {1'b0, r_reg.conv} - {1'b0, drain_source_meas_field};
            r_next.ds_max1  = r_reg.conv > r_reg.thr;
            r_next.ds_st    = HSST_ST_END;
          end
        end else begin
          r_next.cnt = r_reg.cnt - 10'h001;
        end
      end
      HSST_STUCK: begin
        if (ds_conv_valid) begin
          r_next.so_val   = ds_conv_data;
          r_next.so_fresh = 1'b1;
          if (ds_conv_data > r_reg.thr) begin
            r_next.so_max2 = 1'b1;
            r_next.so_st   = HSST_ST_END;
            r_next.state   = HSST_UNLOCKED;
          end
        end
      end
      HSST_LOCKED: begin
        if (unlock_request && !lock_evt) begin
          r_next.state = HSST_UNLOCKED;
        end
      end
      default: begin
        r_next.state = HSST_LOCKED;
      end
    endcase

    // Aborts override completion in the same cycle
    if (in_test && (lock_evt || stop_cmd)) begin
      r_next.state = lock_evt ? HSST_LOCKED : HSST_UNLOCKED;
      if (r_reg.state == HSST_STUCK) begin
        r_next.so_st = HSST_ST_ABORT;
      end else if (r_reg.sel == HSST_SEL_SENSE) begin
        r_next.sense_st = HSST_ST_ABORT;
      end else begin
        r_next.ds_st = HSST_ST_ABORT;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      r_reg <= '{state: HSST_UNLOCKED, cnt: 10'h000, sel: HSST_SEL_NONE, thr: THR_RESET,
                 conv: 10'h000, rdata: 32'h0000_0000, sense_delta: 11'h000,
                 sense_st: HSST_ST_IDLE, ds_delta: 11'h000, ds_max1: 1'b0,
                 ds_st: HSST_ST_IDLE, so_val: 10'h000, so_fresh: 1'b0, so_max2: 1'b0,
                 so_st: HSST_ST_IDLE, fet_q: 1'b0, byp_q: 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  logic test_ds;
  logic test_sense;
  logic timed;

  assign timed      = (r_reg.state == HSST_ACTIVE) || (r_reg.state == HSST_WAIT);
  assign test_sense = timed && (r_reg.sel == HSST_SEL_SENSE);
  assign test_ds    = timed && (r_reg.sel == HSST_SEL_DS);

  assign sense_sink_en  = (r_reg.state == HSST_ACTIVE) && test_sense;
  assign ds_offset_en   = (r_reg.state == HSST_ACTIVE) && test_ds;
  assign sense_conv_req = sense_sink_en;
  assign ds_conv_req    = ds_offset_en || (r_reg.state == HSST_STUCK);

  // Timed tests freeze switch state captured at entry
  assign fet_drive    = (r_reg.state == HSST_STUCK) ? 1'b0 :
                        timed ? r_reg.fet_q : fet_cmd;
  assign bypass_drive = timed ? r_reg.byp_q : bypass_cmd;

  assign drain_source_overvoltage_fault = ds_overvoltage_raw &&
                                          !(test_ds || r_reg.state == HSST_STUCK);

  assign self_test_state = in_test;
  assign locked_state    = (r_reg.state == HSST_LOCKED);

endmodule

`default_nettype wire

/* File: include/hsst_pkg.sv */
// Constants and types for the high-side self-test sequencer.
// Assumes a 100 MHz clock and a 32-bit APB register bus.
package hsst_pkg;

  // Timing
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned PHASE_TIME_NS   = 5000;
  localparam int unsigned PHASE_CYC_INT   = (PHASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0]  PHASE_CYCLES    = PHASE_CYC_INT[9:0];

  // Register byte offsets
  localparam logic [7:0] CTRL_ONE_OFS     = 8'h00;
  localparam logic [7:0] CTRL_TWO_OFS     = 8'h04;
  localparam logic [7:0] DS_TEST_OFS      = 8'h08;
  localparam logic [7:0] STUCK_TEST_OFS   = 8'h0C;
  localparam logic [7:0] SENSE_TEST_OFS   = 8'h10;
  localparam logic [7:0] STATE_OFS        = 8'h14;

  // control_reg_one fields
  localparam int unsigned SEL_LSB         = 0;
  localparam int unsigned START_BIT       = 4;
  localparam int unsigned STOP_BIT        = 8;
  // Test status register fields
  localparam int unsigned DELTA_LSB       = 0;
  localparam int unsigned FLAG_A_BIT      = 12;
  localparam int unsigned FLAG_B_BIT      = 13;
  localparam int unsigned STATUS_LSB      = 16;

  // Reset values
  localparam logic [9:0]  THR_RESET       = 10'h3FF;

  typedef enum logic [1:0] {
    HSST_SEL_NONE  = 2'b00,
    HSST_SEL_SENSE = 2'b01,
    HSST_SEL_DS    = 2'b10,
    HSST_SEL_STUCK = 2'b11
  } hsst_sel_e;

  typedef enum logic [1:0] {
    HSST_ST_IDLE   = 2'b00,
    HSST_ST_RUN    = 2'b01,
    HSST_ST_END    = 2'b10,
    HSST_ST_ABORT  = 2'b11
  } hsst_status_e;

  typedef enum logic [2:0] {
    HSST_UNLOCKED  = 3'b000,
    HSST_ACTIVE    = 3'b001,
    HSST_WAIT      = 3'b010,
    HSST_STUCK     = 3'b011,
    HSST_LOCKED    = 3'b100
  } hsst_state_e;

endpackage

/* File: testbench/hsst_adc_model.sv */
// Converter stand-in: one result pulse every LAT+1 cycles of held request.
// Assumes the request stays high while results are wanted.
`timescale 1ns/1ps
`default_nettype none
module hsst_adc_model #(
  parameter int LAT = 7
) (
  input  wire logic       clk,
  input  wire logic       req,
  input  wire logic [9:0] value,
  output logic            valid,
  output logic [9:0]      data
);
  int cnt = 0;
  initial valid = 1'b0;
  initial data = 10'h0;
  always @(posedge clk) begin
    cnt <= (req && cnt != LAT) ? cnt + 1 : 0;
    valid <= req && cnt == LAT;
    // Scrambled outside result pulses
    data <= (req && cnt == LAT) ? value : ~data;
  end
endmodule
`default_nettype wire

/* File: testbench/hsst_seq_checker.sv */
// Port-level checks for the self-test sequencer.
// Assumes one clock domain; bound into every sequencer instance.
`timescale 1ns/1ps
`default_nettype none
module hsst_seq_checker
  import hsst_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Supervision
  input wire logic        watchdog_timeout,
  input wire logic        hardware_lockout_input,
  // Test stimuli and switches
  input wire logic        sense_sink_en,
  input wire logic        sense_conv_req,
  input wire logic        ds_conv_req,
  input wire logic        ds_offset_en,
  input wire logic        fet_drive,
  input wire logic        bypass_drive,
  input wire logic        bypass_cmd,
  input wire logic        drain_source_overvoltage_fault,
  input wire logic        self_test_state,
  input wire logic        locked_state
);
  logic [9:0] act_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Length of the current active phase
  always_ff @(posedge clk) begin
    if (!nrst)
      act_cnt <= 10'h0;
    else
      act_cnt <= (sense_sink_en || ds_offset_en) ? act_cnt + 10'h1 : 10'h0;
  end
  sequence s_setup; psel && !penable; endsequence
  sequence s_wr_ctl; psel && penable && pwrite && paddr == CTRL_ONE_OFS; endsequence
  sequence s_quiet; !watchdog_timeout && !hardware_lockout_input; endsequence
  property p_ready; s_setup ##1 (psel && penable) |-> pready; endproperty
  property p_err; psel && penable && paddr > STATE_OFS |-> pready && pslverr; endproperty
  property p_start;
    s_wr_ctl ##0 (pwdata[4] && pwdata[1:0] == 2'b01 && !self_test_state && !locked_state)
      ##0 s_quiet |=> sense_sink_en && sense_conv_req && self_test_state;
  endproperty
  property p_stop;
    s_wr_ctl ##0 (pwdata[8] && self_test_state) ##0 s_quiet |=> !self_test_state && !locked_state;
  endproperty
  property p_act_max; (sense_sink_en || ds_offset_en) |-> act_cnt < PHASE_CYCLES; endproperty
  property p_act_end;
    $fell(sense_sink_en || ds_offset_en) && self_test_state |-> act_cnt == PHASE_CYCLES;
  endproperty
  property p_lock;
    (watchdog_timeout || hardware_lockout_input) && self_test_state |=> locked_state && !self_test_state;
  endproperty
  property p_mask; ds_conv_req |-> !drain_source_overvoltage_fault; endproperty
  property p_stuck; ds_conv_req && !ds_offset_en |-> !fet_drive && bypass_drive == bypass_cmd; endproperty
  property p_keep;
    self_test_state && $past(self_test_state) && !(ds_conv_req && !ds_offset_en)
      |-> $stable(fet_drive) && $stable(bypass_drive);
  endproperty
  a_ready: assert property (p_ready) else $error("pready missing in access");
  a_err: assert property (p_err) else $error("unmapped access not refused");
  a_start: assert property (p_start) else $error("sense test did not start");
  a_stop: assert property (p_stop) else $error("stop did not return to unlocked");
  a_act_max: assert property (p_act_max) else $error("active phase too long");
  a_act_end: assert property (p_act_end) else $error("active phase length wrong");
  a_lock: assert property (p_lock) else $error("lock event did not lock");
  a_mask: assert property (p_mask) else $error("overvoltage fault not masked");
  a_stuck: assert property (p_stuck) else $error("stuck-on switch drive wrong");
  a_keep: assert property (p_keep) else $error("switch state changed in test");
endmodule
bind hsst_sequencer hsst_seq_checker u_hsst_chk (.*);
`default_nettype wire

/* File: testbench/test_high_side_self_test_sequencer.sv */
// Self-checking bench for the self-test sequencer.
// Assumes converter stand-ins on both ADC ports and an APB master here.
`timescale 1ns/1ps
`default_nettype none
module test_high_side_self_test_sequencer;
  import hsst_pkg::*;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic        wdog, lock_in, unlock, sv, dv, sreq, dreq, sink, offs;
  logic        fcmd, bcmd, fdrv, bdrv, ovr, ovf, in_test, locked;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [9:0]  smeas, dmeas, sval, dval, sdat, ddat, thr;
  int          errors = 0, check_count = 0, n, dlt_s, dlt_d;
  hsst_sequencer DUT (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .watchdog_timeout(wdog), .hardware_lockout_input(lock_in), .unlock_request(unlock),
    .short_circuit_meas_field(smeas), .drain_source_meas_field(dmeas),
    .sense_conv_valid(sv), .sense_conv_data(sdat), .ds_conv_valid(dv), .ds_conv_data(ddat),
    .sense_conv_req(sreq), .ds_conv_req(dreq), .sense_sink_en(sink), .ds_offset_en(offs),
    .fet_cmd(fcmd), .bypass_cmd(bcmd), .fet_drive(fdrv), .bypass_drive(bdrv),
    .ds_overvoltage_raw(ovr), .drain_source_overvoltage_fault(ovf),
    .self_test_state(in_test), .locked_state(locked));
  hsst_adc_model s_adc (.clk(clk), .req(sreq), .value(sval), .valid(sv), .data(sdat));
  hsst_adc_model d_adc (.clk(clk), .req(dreq), .value(dval), .valid(dv), .data(ddat));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] word(int d, int a, int b, int s);
    return 32'(d & 32'h7FF | a << 12 | b << 13 | s << 16);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run_out(output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (in_test !== 1'b0 && c < 3000);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    finish_test;
  end
  initial begin
    {nrst, psel, penable, pwrite, wdog, lock_in, unlock, ovr, fcmd, bcmd} = 10'h7;
    paddr = 8'h0;
    pwdata = 32'h0;
    seed = 32'h0BC5;
    repeat (40) seed = lfsr(seed);
    // Sensed values kept below half of converter full scale
    sval = {1'b0, seed[8:0]};
    smeas = {1'b0, seed[18:10]};
    dval = {1'b0, seed[27:19]} | 10'h1;
    dmeas = {2'h0, seed[31:24]};
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    apb(0, CTRL_TWO_OFS, 0);
    chk(rd, 32'h3FF);
    chk(err, 0);
    chk(ovf, 1);
    apb(1, CTRL_ONE_OFS, 32'h10);
    apb(0, STATE_OFS, 0);
    chk(rd, 0);
    apb(0, 8'h20, 0);
    chk({err, rd[0]}, 2'b10);
    $display("test registers done");
    fcmd <= 1'b1;
    apb(1, CTRL_ONE_OFS, 32'h11);
    fcmd <= 1'b0;
    bcmd <= 1'b0;
    repeat (50) @(posedge clk);
    chk({fdrv, bdrv}, 2'b11);
    run_out(n);
    chk(n + 50 >= 900 && n + 50 <= 1100, 1);
    dlt_s = int'(sval) - int'(smeas);
    apb(0, SENSE_TEST_OFS, 0);
    chk(rd, word(dlt_s, 0, 0, 2));
    $display("test sense done");
    thr = dval - 10'h1;
    apb(1, CTRL_TWO_OFS, {22'h0, thr});
    apb(1, CTRL_ONE_OFS, 32'h12);
    repeat (50) @(posedge clk);
    chk(ovf, 0);
    run_out(n);
    chk(n + 50 >= 900 && n + 50 <= 1100, 1);
    dlt_d = int'(dval) - int'(dmeas);
    apb(0, DS_TEST_OFS, 0);
    chk(rd, word(dlt_d, 1, 0, 2));
    $display("test drain-source done");
    apb(1, CTRL_TWO_OFS, 32'h3FF);
    fcmd <= 1'b1;
    bcmd <= 1'b0;
    apb(1, CTRL_ONE_OFS, 32'h13);
    bcmd <= 1'b1;
    repeat (30) @(posedge clk);
    chk({fdrv, bdrv}, {1'b0, bcmd});
    apb(0, STUCK_TEST_OFS, 0);
    chk(rd, word(dval, 1, 0, 1));
    apb(1, CTRL_ONE_OFS, 32'h100);
    apb(0, STUCK_TEST_OFS, 0);
    chk(rd[17:13], 5'b11000);
    apb(1, CTRL_TWO_OFS, {22'h0, thr});
    apb(1, CTRL_ONE_OFS, 32'h13);
    run_out(n);
    chk(n < 50, 1);
    apb(0, STUCK_TEST_OFS, 0);
    chk(rd, word(dval, 1, 1, 2));
    $display("test stuck-on done");
    // Aborts: lock-out, watchdog, stop in wait phase
    for (int i = 0; i < 3; i++) begin
      apb(1, CTRL_ONE_OFS, i == 1 ? 32'h12 : 32'h11);
      repeat (100 + 400 * i) @(posedge clk);
      if (i == 2) apb(1, CTRL_ONE_OFS, 32'h100);
      else {wdog, lock_in} <= i == 1 ? 2'b10 : 2'b01;
      @(posedge clk);
      {wdog, lock_in} <= 2'b00;
      @(posedge clk);
      chk({in_test, locked}, i == 2 ? 0 : 1);
      apb(0, i == 1 ? DS_TEST_OFS : SENSE_TEST_OFS, 0);
      // Emulated flag is cleared at start and not set by an abort
      chk(rd, i == 1 ? word(dlt_d, 0, 0, 3) : word(dlt_s, 0, 0, 3));
      apb(1, CTRL_ONE_OFS, 32'h11);
      apb(0, STATE_OFS, 0);
      chk(rd, i == 2 ? 1 : 4);
      unlock <= 1'b1;
      @(posedge clk);
      unlock <= 1'b0;
      run_out(n);
    end
    $display("test aborts done");
    finish_test;
  end
endmodule
`default_nettype wire
